// File: common/spz_consts.vh
// Register offsets, field positions and timing counts for serial port zero.
`ifndef SPZ_CONSTS_VH
`define SPZ_CONSTS_VH
`define SPZ_ADDR_CONTROL 8'h98
`define SPZ_ADDR_BUFFER 8'h99
`define SPZ_CONTROL_RESET 8'h00
`define SPZ_BUFFER_RESET 8'h00
`define SPZ_BIT_MODE_HIGH 7
`define SPZ_BIT_MODE_LOW 6
`define SPZ_BIT_THIRD 5
`define SPZ_BIT_RX_ENABLE 4
`define SPZ_BIT_TX_NINTH 3
`define SPZ_BIT_RX_NINTH 2
`define SPZ_BIT_TX_DONE 1
`define SPZ_BIT_RX_DONE 0
`define SPZ_SYNC_SLOW 10'd12
`define SPZ_SYNC_FAST 10'd4
`define SPZ_M2_SLOW 10'd64
`define SPZ_M2_FAST 10'd32
`define SPZ_FIFO_WIDTH 8
`define SPZ_FIFO_DEPTH 16
`define SPZ_FIFO_AW 4
`endif

// File: rtl/spz_fifo.v
// Transmit byte FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module spz_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // spz_fifo

// File: rtl/spz_uart.v
// Serial port zero: control and buffer registers, transmitter and receiver.
`timescale 1ns/100ps
`include "spz_consts.vh"
// Functional notes
// (RL1) Async frames: start, 8/9 data, stop.
// (RL2) Mode bits pick mode and bit period.
// (RL3) Modes 1/3 use timer 1 or 2 tick; mode 1 with the third mode bit set always takes the timer 1 tick.
// (RL4) Bit timing stops while idle mode.
// (RL5) Mode 1 third bit: need valid stop.
// (RL6) Multiprocessor: ninth bit zero, no flag.
// (RL7) Receive enable gates receiver; mode 0 starts.
// (RL8) Transmit ninth bit from control bit.
// (RL9) Receive ninth bit or stop stored; mode 1 stores the stop bit only with the third mode bit clear.
// (RL10) Transmit-done set after last data bit.
// (RL11) Receive-done set at documented point.
// (RL12) Only software clears done flags.
// (RL13) Buffer address: separate tx and rx.
// (RL14) Buffer write starts send; flags interrupt.
// (RL15) Start edge detect, mid-bit sampling.
module spz_uart (
    input wire clk,
    input wire rst,
    input wire idle_mode,
    input wire baud_doubler,
    input wire timer_two_select,
    input wire timer1_tick,
    input wire timer2_tick,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output wire tx_ready,
    output reg txd,
    output reg rxd_out,
    output reg rxd_oe,
    input wire rxd_in,
    output wire serial_irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_STOP = 2'd2;

    reg [7:0] serial_control;
    reg [7:0] rx_buffer;
    reg rx_s1;
    reg rx_s2;
    reg rx_prev;
    reg [1:0] rx_state;
    reg rx_phase;

    wire mode_select_high = serial_control[`SPZ_BIT_MODE_HIGH];
    wire mode_select_low = serial_control[`SPZ_BIT_MODE_LOW];
    wire third_mode_bit = serial_control[`SPZ_BIT_THIRD];
    wire rx_enable = serial_control[`SPZ_BIT_RX_ENABLE];
    wire [1:0] mode = {mode_select_high, mode_select_low};
    wire nine_bits = mode_select_high;
    wire rx_mode0_idle = !(mode == 2'd0 && rx_state != ST_IDLE);

    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    // Bits in modes 1 to 3 last 16 ticks; mode 2 derives the tick and mode 0 its shift steps here.
    reg [9:0] pre_cnt;
    wire [9:0] sync_period = third_mode_bit ? `SPZ_SYNC_FAST : `SPZ_SYNC_SLOW; // [RL2]
    wire [9:0] m2_period = baud_doubler ? `SPZ_M2_FAST : `SPZ_M2_SLOW; // [RL2]
    wire [9:0] m2_tick_div = {4'b0000, m2_period[9:4]};
    wire timer_tick = (timer_two_select && !(mode == 2'd1 && third_mode_bit))
        ? timer2_tick : timer1_tick; // [RL3]
    wire m2_tick = (pre_cnt >= m2_tick_div - 10'd1);
    wire sync_edge = (pre_cnt >= {1'b0, sync_period[9:1]} - 10'd1); // [RL2]
    wire tick = !idle_mode && ((mode == 2'd2) ? m2_tick : timer_tick); // [RL4]
    wire sync_step = !idle_mode && sync_edge; // [RL4]

    always @(posedge clk) begin
        if (rst) begin
            pre_cnt <= 10'h000;
        end else if (!idle_mode) begin // [RL4]
            if ((mode == 2'd0 && sync_edge) || (mode == 2'd2 && m2_tick)) begin
                pre_cnt <= 10'h000;
            end else begin
                pre_cnt <= pre_cnt + 10'd1;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s1 <= rxd_in;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    wire wr_ctrl = sfr_wr && (sfr_addr == `SPZ_ADDR_CONTROL);
    wire wr_buf = sfr_wr && (sfr_addr == `SPZ_ADDR_BUFFER);
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_pop;
    reg tx_done_set;
    reg rx_done_set;
    reg rx_ninth_set;
    reg rx_ninth_val;
    reg rx_load;
    reg [7:0] rx_load_data;

    spz_fifo #(
        .WIDTH(`SPZ_FIFO_WIDTH),
        .DEPTH(`SPZ_FIFO_DEPTH),
        .AW(`SPZ_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(wr_buf), // [RL14]
        .in_ready(tx_ready),
        .in_data(sfr_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    always @(posedge clk) begin
        if (rst) begin
            serial_control <= `SPZ_CONTROL_RESET;
            rx_buffer <= `SPZ_BUFFER_RESET;
        end else begin
            if (wr_ctrl) begin
                serial_control <= sfr_wdata;
            end
            // Hardware sets win over a same-cycle software clear.
            if (tx_done_set) begin
                serial_control[`SPZ_BIT_TX_DONE] <= 1'b1; // [RL12]
            end
            if (rx_done_set) begin
                serial_control[`SPZ_BIT_RX_DONE] <= 1'b1; // [RL12]
            end
            if (rx_ninth_set) begin
                serial_control[`SPZ_BIT_RX_NINTH] <= rx_ninth_val; // [RL9]
            end
            if (rx_load) begin
                rx_buffer <= rx_load_data; // [RL13]
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `SPZ_ADDR_CONTROL: sfr_rdata <= serial_control;
                `SPZ_ADDR_BUFFER: sfr_rdata <= rx_buffer; // [RL13]
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    assign serial_irq = serial_control[`SPZ_BIT_TX_DONE]
        | serial_control[`SPZ_BIT_RX_DONE]; // [RL14]

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    reg [1:0] tx_state;
    reg [10:0] tx_shift;
    reg [3:0] tx_bits;
    reg [3:0] tx_sub;
    reg sync_phase;

    always @(posedge clk) begin
        if (rst) begin
            tx_state <= ST_IDLE;
            tx_shift <= 11'h7FF;
            tx_bits <= 4'h0;
            tx_sub <= 4'h0;
            txd <= 1'b1;
            fifo_pop <= 1'b0;
            tx_done_set <= 1'b0;
            sync_phase <= 1'b0;
        end else begin
            fifo_pop <= 1'b0;
            tx_done_set <= 1'b0;
            case (tx_state)
                ST_IDLE: begin
                    // In mode 0 the idle transmit pin carries the receive shift clock.
                    txd <= !(mode == 2'd0 && rx_state == ST_SHIFT && rx_phase); // [RL7]
                    if (fifo_out_valid && !fifo_pop && rx_mode0_idle) begin // [RL14]
                        fifo_pop <= 1'b1;
                        tx_sub <= 4'h0;
                        sync_phase <= 1'b0;
                        tx_state <= ST_SHIFT;
                        if (mode == 2'd0) begin
                            tx_shift <= {3'b111, fifo_out_data};
                            tx_bits <= 4'd8;
                        end else begin
                            // Stop, optional ninth, data, start shift out LSB first.
                            tx_shift <= nine_bits
                                ? {1'b1, serial_control[`SPZ_BIT_TX_NINTH], fifo_out_data, 1'b0}
                                : {2'b11, fifo_out_data, 1'b0}; // [RL1] [RL8]
                            tx_bits <= nine_bits ? 4'd10 : 4'd9;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (mode == 2'd0) begin
                        if (sync_step) begin
                            sync_phase <= ~sync_phase;
                            if (!sync_phase) begin
                                txd <= 1'b0;
                            end else begin
                                txd <= 1'b1;
                                tx_shift <= {1'b1, tx_shift[10:1]};
                                tx_bits <= tx_bits - 4'd1;
                                if (tx_bits == 4'd1) begin
                                    tx_done_set <= 1'b1; // [RL10]
                                    tx_state <= ST_IDLE;
                                end
                            end
                        end
                    end else begin
                        txd <= tx_shift[0];
                        if (tick) begin
                            tx_sub <= tx_sub + 4'd1;
                            if (tx_sub == 4'hF) begin
                                tx_shift <= {1'b1, tx_shift[10:1]};
                                tx_bits <= tx_bits - 4'd1;
                                if (tx_bits == 4'd1) begin
                                    tx_done_set <= 1'b1; // [RL10]
                                    tx_state <= ST_STOP;
                                end
                            end
                        end
                    end
                end
                ST_STOP: begin
                    txd <= 1'b1;
                    if (tick) begin
                        tx_sub <= tx_sub + 4'd1;
                        if (tx_sub == 4'hF) begin
                            tx_state <= ST_IDLE;
                        end
                    end
                end
                default: tx_state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    reg [9:0] rx_shift;
    reg [3:0] rx_bits;
    reg [3:0] rx_sub;
    // Eight data bits, then the stop bit (mode 1) or the ninth bit (modes 2 and 3).
    wire [3:0] rx_total = 4'd9; // [RL11]

    always @(posedge clk) begin
        if (rst) begin
            rx_state <= ST_IDLE;
            rx_shift <= 10'h000;
            rx_bits <= 4'h0;
            rx_sub <= 4'h0;
            rx_phase <= 1'b0;
            rx_done_set <= 1'b0;
            rx_ninth_set <= 1'b0;
            rx_ninth_val <= 1'b0;
            rx_load <= 1'b0;
            rx_load_data <= 8'h00;
            rxd_out <= 1'b1;
            rxd_oe <= 1'b0;
        end else begin
            rx_done_set <= 1'b0;
            rx_ninth_set <= 1'b0;
            rx_load <= 1'b0;
            // Mode 0 transmit data leaves on the receive pin, driven only then.
            rxd_oe <= (mode == 2'd0) && (tx_state == ST_SHIFT); // [RL2]
            rxd_out <= ((mode == 2'd0) && (tx_state == ST_SHIFT)) ? tx_shift[0] : 1'b1;
            if (!rx_enable) begin
                rx_state <= ST_IDLE; // [RL7]
            end else begin
                case (rx_state)
                    ST_IDLE: begin
                        rx_sub <= 4'h0;
                        rx_phase <= 1'b0;
                        if (mode == 2'd0) begin
                            // Mode 0 receive starts once enable is set with no done flag, the transmitter idle and its FIFO empty.
                            if (!serial_control[`SPZ_BIT_RX_DONE] && tx_state == ST_IDLE
                                && !fifo_out_valid) begin // [RL7]
                                rx_bits <= 4'd8;
                                rx_state <= ST_SHIFT;
                            end
                        end else if (rx_prev && !rx_s2) begin // [RL15]
                            rx_bits <= rx_total;
                            rx_state <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        // Validate the start bit at its middle.
                        if (tick) begin
                            rx_sub <= rx_sub + 4'd1;
                            if (rx_sub == 4'd7) begin
                                rx_sub <= 4'h0;
                                rx_state <= rx_s2 ? ST_IDLE : ST_SHIFT; // [RL15]
                            end
                        end
                    end
                    ST_SHIFT: begin
                        if (mode == 2'd0) begin
                            if (sync_step) begin
                                rx_phase <= ~rx_phase;
                                if (rx_phase) begin
                                    rx_shift <= {2'b00, rx_s2, rx_shift[7:1]};
                                    rx_bits <= rx_bits - 4'd1;
                                    if (rx_bits == 4'd1) begin
                                        rx_load <= 1'b1;
                                        rx_load_data <= {rx_s2, rx_shift[7:1]};
                                        rx_done_set <= 1'b1; // [RL11]
                                        rx_state <= ST_IDLE;
                                    end
                                end
                            end
                        end else if (tick) begin
                            rx_sub <= rx_sub + 4'd1;
                            if (rx_sub == 4'hF) begin // [RL15]
                                rx_shift <= {rx_s2, rx_shift[9:1]};
                                rx_bits <= rx_bits - 4'd1;
                                if (rx_bits == 4'd1) begin
                                    rx_state <= ST_IDLE;
                                    if (mode == 2'd1) begin
                                        // Mode 1: data in shift[9:2], stop is rx_s2.
                                        if (!third_mode_bit || rx_s2) begin // [RL5]
                                            rx_load <= 1'b1;
                                            rx_load_data <= rx_shift[9:2];
                                            rx_done_set <= 1'b1; // [RL11]
                                            rx_ninth_set <= !third_mode_bit; // [RL9]
                                            rx_ninth_val <= rx_s2;
                                        end
                                    end else if (!third_mode_bit || rx_s2) begin // [RL6]
                                        rx_load <= 1'b1;
                                        rx_load_data <= rx_shift[9:2];
                                        rx_done_set <= 1'b1; // [RL11]
                                        rx_ninth_set <= 1'b1; // [RL9]
                                        rx_ninth_val <= rx_s2;
                                    end
                                end
                            end
                        end
                    end
                    default: rx_state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // spz_uart

// File: test/spz_uart_properties.sv
// Concurrent checks on the serial port zero ports.
`timescale 1ns/100ps
module spz_uart_properties (
    input wire clk,
    input wire rst,
    input wire idle_mode,
    input wire baud_doubler,
    input wire timer_two_select,
    input wire timer1_tick,
    input wire timer2_tick,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire tx_ready,
    input wire txd,
    input wire rxd_out,
    input wire rxd_oe,
    input wire rxd_in,
    input wire serial_irq
);
    // Software copy of the control bits that hardware never changes.
    reg [7:0] ctrl_shadow;
    always @(posedge clk) begin
        if (rst) begin
            ctrl_shadow <= 8'h00;
        end else if (sfr_wr && sfr_addr == 8'h98) begin
            ctrl_shadow <= sfr_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_reset_state;
        $fell(rst) |-> txd && !rxd_oe && tx_ready && sfr_rdata == 8'h00 && !serial_irq;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_unmapped;
        sfr_rd && sfr_addr != 8'h98 && sfr_addr != 8'h99 |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rdata_hold;
        !sfr_rd |=> $stable(sfr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_irq_read;
        sfr_rd && sfr_addr == 8'h98 |=> (sfr_rdata[1] | sfr_rdata[0]) == $past(serial_irq);
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("irq differs from flags");
    property p_no_self_clear;
        $fell(serial_irq) |-> $past(sfr_wr) && $past(sfr_addr) == 8'h98;
    endproperty
    a_no_self_clear: assert property (p_no_self_clear) else $error("flag cleared alone");
    property p_sw_set;
        sfr_wr && sfr_addr == 8'h98 && sfr_wdata[0] |=> serial_irq;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("written flag not seen");
    property p_ctrl_bits;
        sfr_rd && sfr_addr == 8'h98 |=> sfr_rdata[7:3] == ctrl_shadow[7:3];
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("control bits wrong");
    property p_async_oe;
        ctrl_shadow[7:6] != 2'b00 |-> !rxd_oe;
    endproperty
    a_async_oe: assert property (p_async_oe) else $error("receive pin driven");
    property p_idle_freeze;
        idle_mode && $past(idle_mode) && $past(idle_mode, 2) && !$past(sfr_wr)
            && ctrl_shadow[7:6] != 2'b00 |-> $stable(txd);
    endproperty
    a_idle_freeze: assert property (p_idle_freeze) else $error("txd moved in idle");
    c_full: cover property (!tx_ready);
    c_sync_drive: cover property (rxd_oe);
    c_rx_flag: cover property (sfr_rd && sfr_addr == 8'h98 ##1 sfr_rdata[0]);
endmodule // spz_uart_properties
bind spz_uart spz_uart_properties u_props (.clk(clk), .rst(rst), .idle_mode(idle_mode),
    .baud_doubler(baud_doubler), .timer_two_select(timer_two_select),
    .timer1_tick(timer1_tick), .timer2_tick(timer2_tick), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .tx_ready(tx_ready), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .rxd_in(rxd_in), .serial_irq(serial_irq));

// File: test/spz_remote_model.sv
// Remote serial transceiver facing the transmit and receive lines.
`timescale 1ns/100ps
module spz_remote_model (
    input wire clk,
    input wire txd,
    input wire [3:0] data_bits,
    input wire [7:0] bit_clk,
    output reg line_out
);
    reg [8:0] got;
    reg got_stop;
    integer frames;
    integer i;
    initial begin
        line_out = 1'b1;
        got = 9'h000;
        got_stop = 1'b0;
        frames = 0;
    end
    // Sends start, data LSB first, then the given stop level; idle line is high.
    task automatic send(input logic [8:0] data, input logic stop);
        integer k;
        @(posedge clk);
        #2 line_out = 1'b0;
        repeat (bit_clk) @(posedge clk);
        for (k = 0; k < data_bits; k++) begin
            #2 line_out = data[k];
            repeat (bit_clk) @(posedge clk);
        end
        #2 line_out = stop;
        repeat (bit_clk) @(posedge clk);
        #2 line_out = 1'b1;
    endtask
    // Decodes transmitted frames by sampling each bit in its middle.
    always begin
        @(negedge txd);
        repeat (bit_clk / 2) @(posedge clk);
        if (txd === 1'b0) begin
            got = 9'h000;
            for (i = 0; i < data_bits; i++) begin
                repeat (bit_clk) @(posedge clk);
                got[i] = txd;
            end
            repeat (bit_clk) @(posedge clk);
            got_stop = txd;
            frames = frames + 1;
        end
    end
endmodule // spz_remote_model

// File: test/spz_uart_tb_top.sv
// Self-checking bench for serial port zero.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t: got %h want %h", $time, g, e); end end
module spz_uart_tb_top;
    reg clk, rst, idle_mode, baud_doubler, timer_two_select, timer1_tick, timer2_tick;
    reg sfr_wr, sfr_rd, level;
    reg [7:0] sfr_addr, sfr_wdata, bit_clk;
    reg [3:0] data_bits;
    reg [1:0] tick_cnt;
    reg [26:0] e;
    wire [7:0] sfr_rdata;
    wire tx_ready, txd, rxd_out, rxd_oe, serial_irq, line_out;
    wire rxd_in = rxd_oe ? rxd_out : line_out;
    integer num_errors, check_count, cycles, i;
    reg [7:0] m0_got;
    // Collects mode 0 transmit data at each rising shift clock.
    always @(posedge txd) begin
        if (rxd_oe) begin
            m0_got <= {rxd_out, m0_got[7:1]};
        end
    end
    // Entries: control, expected control (00 = no flag), stop, timer select, data.
    localparam logic [26:0] CASES [0:6] = '{{8'h50, 8'h55, 1'b1, 1'b0, 9'h05A},
        {8'h70, 8'h00, 1'b0, 1'b0, 9'h033}, {8'h70, 8'h71, 1'b1, 1'b1, 9'h0C6},
        {8'h40, 8'h00, 1'b1, 1'b0, 9'h077}, {8'hF0, 8'h00, 1'b1, 1'b0, 9'h012},
        {8'hF0, 8'hF5, 1'b1, 1'b0, 9'h19C}, {8'h90, 8'h91, 1'b1, 1'b0, 9'h0E1}};
    spz_uart DUT (.clk(clk), .rst(rst), .idle_mode(idle_mode), .baud_doubler(baud_doubler),
        .timer_two_select(timer_two_select), .timer1_tick(timer1_tick),
        .timer2_tick(timer2_tick), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_ready(tx_ready), .txd(txd),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in), .serial_irq(serial_irq));
    spz_remote_model u_model (.clk(clk), .txd(txd), .data_bits(data_bits),
        .bit_clk(bit_clk), .line_out(line_out));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Timer 1 ticks every 4 clocks (64 per bit), timer 2 every 2 clocks (32 per bit).
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'd1;
        timer1_tick <= #2 (tick_cnt == 2'd3);
        timer2_tick <= #2 tick_cnt[0];
        cycles = cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #2 sfr_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        @(posedge clk);
        #2 sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #2 sfr_rd = 1'b0;
        `CHK(sfr_rdata & m, x)
    endtask
    task automatic wait_irq(input integer max);
        integer n;
        n = 0;
        while (serial_irq !== 1'b1 && n < max) begin
            @(posedge clk);
            n++;
        end
        #3;
    endtask
    task automatic wait_frames(input integer n);
        integer k;
        k = 0;
        while (u_model.frames < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask
    initial begin
        {rst, idle_mode, baud_doubler, timer_two_select, timer1_tick, timer2_tick} = 6'b100000;
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, tick_cnt} = 20'h00000;
        {num_errors, check_count, cycles} = 0;
        bit_clk = 8'd64;
        data_bits = 4'd8;
        repeat (20) @(posedge clk);
        #2 rst = 1'b0;
        rd_chk(8'h98, 8'hFF, 8'h00);
        rd_chk(8'h99, 8'hFF, 8'h00);
        rd_chk(8'h9A, 8'hFF, 8'h00);
        wr(8'h98, 8'h40);
        wr(8'h99, 8'hA5);
        wait_irq(1000);
        `CHK(u_model.frames, 0)
        wait_frames(1);
        `CHK(u_model.got[7:0], 8'hA5)
        `CHK(u_model.got_stop, 1'b1)
        rd_chk(8'h98, 8'hFF, 8'h42);
        wr(8'h98, 8'h40);
        `CHK(serial_irq, 1'b0)
        wr(8'h98, 8'h41);
        `CHK(serial_irq, 1'b1)
        timer_two_select = 1'b1;
        bit_clk = 8'd32;
        data_bits = 4'd9;
        wr(8'h98, 8'hC8);
        wr(8'h99, 8'h3C);
        wait_frames(2);
        `CHK(u_model.got, 9'h13C)
        rd_chk(8'h98, 8'hFF, 8'hCA);
        bit_clk = 8'd64;
        for (i = 0; i < 7; i++) begin
            e = CASES[i];
            timer_two_select = e[9];
            data_bits = e[26] ? 4'd9 : 4'd8;
            wr(8'h98, e[26:19]);
            u_model.send(e[8:0], e[10]);
            if (e[18:11] != 8'h00) begin
                wait_irq(200);
                rd_chk(8'h98, (e[24] && !e[26]) ? 8'hFB : 8'hFF, e[18:11]);
                rd_chk(8'h99, 8'hFF, e[7:0]);
            end else begin
                repeat (100) @(posedge clk);
                #2;
                `CHK(serial_irq, 1'b0)
            end
        end
        baud_doubler = 1'b1;
        bit_clk = 8'd32;
        data_bits = 4'd9;
        wr(8'h98, 8'h88);
        wr(8'h99, 8'hE7);
        rd_chk(8'h99, 8'hFF, 8'hE1);
        wait_frames(3);
        `CHK(u_model.got, 9'h1E7)
        wr(8'h98, 8'h88);
        wr(8'h99, 8'hC3);
        repeat (80) @(posedge clk);
        #2 idle_mode = 1'b1;
        @(posedge clk);
        #2 level = txd;
        repeat (300) @(posedge clk);
        #2 idle_mode = 1'b0;
        `CHK(txd, level)
        `CHK(serial_irq, 1'b0)
        wait_irq(800);
        `CHK(serial_irq, 1'b1)
        repeat (100) @(posedge clk);
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h96);
        wait_irq(1000);
        rd_chk(8'h98, 8'hFF, 8'h02);
        `CHK(m0_got, 8'h96)
        wr(8'h98, 8'h10);
        wait_irq(1000);
        rd_chk(8'h98, 8'hFF, 8'h11);
        rd_chk(8'h99, 8'hFF, 8'hFF);
        wr(8'h98, 8'h40);
        @(posedge clk);
        #2 sfr_addr = 8'h99;
        sfr_wr = 1'b1;
        repeat (17) @(posedge clk);
        #2 sfr_wr = 1'b0;
        `CHK(tx_ready, 1'b0)
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #2 rst = 1'b0;
        `CHK(tx_ready, 1'b1)
        `CHK(txd, 1'b1)
        rd_chk(8'h98, 8'hFF, 8'h00);
        complete_run();
    end
endmodule // spz_uart_tb_top
